// ---- core/ssp_fifo.sv ----
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ns
module ssp_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [W-1:0] i_wr_data,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [W-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic do_wr;
  logic do_rd;

  assign o_wr_ready = (count_r != (AW+1)'(DEPTH));
  assign o_rd_valid = (count_r != '0);
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = i_rd_ready && o_rd_valid;
  assign o_rd_data = mem[rd_ptr_r];

  always_ff @(posedge i_clk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= i_wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

// ---- core/ssp_framer.sv ----
// Frame engine of a synchronous serial port: SPI and command-response.
// Assumes config is stable while busy; pins are asynchronous to i_clk.
//
// Behaviour
// - Idle: frame select high, data out low, bit clock at polarity level.
// - Master drives bit clock pad; slave releases it and uses external clock.
// - Enabled master with queued word starts frame: select low, data out enabled.
// - Polarity 0 phase 1: data and first rising edge half bit after select falls.
// - Polarity 1 phase 0: master data after half bit, first falling after another.
// - Polarity 1 phase 1: data and first falling edge half bit after select.
// - Master raises frame select one bit period after the final capture.
// - Phase 0 back-to-back words: frame select pulses high between words.
// - Phase 1 back-to-back words: frame select stays low until last word.
// - Command-response frame opens with 8-bit control word, nothing received.
// - Queued control byte triggers frame; MSB driven as select falls.
// - Select low all frame; input ignored while control word goes out.
// - Polarity 0: peripheral drives reply on falling edges; port latches on rising.
// - Single frame: select rises one bit after last reply bit, on the same clock as the reply is stored.
// - Continuous frames: select stays low, next control follows, reply stored.
// - Slave in command-response samples first bit on first rising edge.
// - Words are 4 to 16 bits, most significant bit first.
// - Transmit and receive FIFOs are 16 bits wide, eight deep.
`timescale 1ns/1ns
`include "ssp_framer_defines.svh"
module ssp_framer
  import ssp_framer_pkg::*;
#(
  parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire cfg_t i_cfg,
  input wire logic [7:0] i_half_div,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [`SSP_DATA_W-1:0] i_tx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output logic [`SSP_DATA_W-1:0] o_rx_data,
  output logic o_busy,
  output logic o_serial_bit_clock,
  output logic o_serial_bit_clock_oe_n,
  input wire logic i_serial_bit_clock,
  output logic o_frame_select_line,
  output logic o_frame_select_line_oe_n,
  input wire logic i_frame_select_line,
  output logic o_serial_out_line,
  output logic o_serial_out_line_oe_n,
  input wire logic i_serial_in_line
);
  localparam logic [5:0] CR_BASE = 6'(2 * `SSP_CTRL_BITS + 2);
  localparam logic [5:0] CTRL_END = 6'(2 * `SSP_CTRL_BITS);

  function automatic logic [15:0] align_msb(input logic [15:0] w, input logic [4:0] n);
    align_msb = w << (5'h10 - n);
  endfunction

  function automatic logic [15:0] word_mask(input logic [4:0] n);
    word_mask = 16'hFFFF >> (5'h10 - n);
  endfunction

  // Transmit and receive queues
  logic tx_avail;
  logic tx_pop;
  logic [15:0] tx_word;
  logic rx_push;
  logic [15:0] rx_word;
  logic rx_space;

  ssp_fifo #(.W(`SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(i_tx_valid),
    .o_wr_ready(o_tx_ready),
    .i_wr_data(i_tx_data),
    .o_rd_valid(tx_avail),
    .i_rd_ready(tx_pop),
    .o_rd_data(tx_word)
  );

  ssp_fifo #(.W(`SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr_valid(rx_push),
    .o_wr_ready(rx_space),
    .i_wr_data(rx_word),
    .o_rd_valid(o_rx_valid),
    .i_rd_ready(i_rx_ready),
    .o_rd_data(o_rx_data)
  );

  // Pin synchronisers; only stage two and later feed logic
  logic [1:0] sclk_sync_r;
  logic [1:0] fss_sync_r;
  logic [1:0] sin_sync_r;
  logic sclk_d_r;
  logic fss_d_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_sync_r <= 2'h0;
      fss_sync_r <= 2'h3;
      sin_sync_r <= 2'h0;
      sclk_d_r <= 1'b0;
      fss_d_r <= 1'b1;
    end else begin
      sclk_sync_r <= {sclk_sync_r[0], i_serial_bit_clock};
      fss_sync_r <= {fss_sync_r[0], i_frame_select_line};
      sin_sync_r <= {sin_sync_r[0], i_serial_in_line};
      sclk_d_r <= sclk_sync_r[1];
      fss_d_r <= fss_sync_r[1];
    end
  end

  logic sin_s;
  assign sin_s = sin_sync_r[1];

  // Half bit period tick from the divider
  logic [7:0] div_cnt_r;
  logic tick;
  assign tick = (div_cnt_r == 8'h00);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt_r <= `SSP_HALF_DIV_RST;
    end else if (tick) begin
      div_cnt_r <= (i_half_div == 8'h00) ? 8'h00 : i_half_div - 8'h01;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h01;
    end
  end

  // Master sequencer, counted in half bit periods
  mstate_t mstate_r;
  logic [5:0] half_r;
  logic [5:0] n2;
  logic m_tog;
  logic m_cap;
  logic m_shf;
  logic [5:0] cont_half;
  logic [5:0] end_half;
  logic m_more;
  logic m_start;
  logic m_cont;
  logic m_end;

  assign n2 = {i_cfg.bits, 1'b0};
  assign cont_half = i_cfg.cmdresp ? n2 + CR_BASE : n2 + 6'h02;
  assign end_half = i_cfg.cmdresp ? n2 + CR_BASE + 6'h01 : n2 + 6'h02;

  always_comb begin
    if (i_cfg.cmdresp) begin
      m_tog = (half_r >= 6'h01) && (half_r <= cont_half);
      m_cap = half_r[0] && (half_r > CR_BASE) && (half_r < cont_half);
      m_shf = !half_r[0] && (half_r >= 6'h02) && (half_r <= CTRL_END);
    end else if (i_cfg.cpha) begin
      m_tog = (half_r >= 6'h01) && (half_r <= n2);
      m_cap = !half_r[0] && (half_r >= 6'h02) && (half_r <= n2);
      m_shf = half_r[0] && (half_r < n2);
    end else begin
      m_tog = (half_r >= 6'h02) && (half_r <= n2 + 6'h01);
      m_cap = !half_r[0] && (half_r >= 6'h02) && (half_r <= n2);
      m_shf = half_r[0] && (half_r < n2);
    end
  end

  // Phase 1 and command-response may chain words without raising select
  assign m_more = i_enable && tx_avail && (i_cfg.cmdresp || i_cfg.cpha);
  assign m_start = tick && (mstate_r == ST_IDLE) && i_enable && tx_avail && i_cfg.master;
  assign m_cont = tick && (mstate_r == ST_RUN) && (half_r == cont_half) && m_more;
  assign m_end = tick && (mstate_r == ST_RUN) && (half_r == end_half) && !m_cont;

  logic [15:0] m_tx_sh_r;
  logic [15:0] m_rx_sh_r;
  logic m_sclk_r;
  logic m_fss_r;
  logic m_sout_r;
  logic m_sout_en_r;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mstate_r <= ST_IDLE;
      half_r <= 6'h00;
    end else begin
      case (mstate_r)
        ST_IDLE: begin
          half_r <= 6'h00;
          if (m_start) begin
            mstate_r <= ST_RUN;
            half_r <= 6'h01;
          end
        end
        ST_RUN: begin
          if (m_cont) begin
            half_r <= 6'h01;
          end else if (m_end) begin
            mstate_r <= ST_GAP;
            half_r <= 6'h00;
          end else if (tick) begin
            half_r <= half_r + 6'h01;
          end
        end
        ST_GAP: begin
          if (tick) begin
            if (half_r == `SSP_GAP_HALVES - 6'h01) begin
              mstate_r <= ST_IDLE;
            end
            half_r <= half_r + 6'h01;
          end
        end
        default: begin
          mstate_r <= ST_IDLE;
          half_r <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      m_sclk_r <= 1'b0;
      m_fss_r <= `SSP_FSS_IDLE;
    end else if (mstate_r != ST_RUN) begin
      m_sclk_r <= i_cfg.cpol;
      m_fss_r <= m_start ? 1'b0 : `SSP_FSS_IDLE;
    end else if (tick) begin
      if (m_tog) begin
        m_sclk_r <= ~m_sclk_r;
      end
      if (m_end) begin
        m_fss_r <= `SSP_FSS_IDLE;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      m_tx_sh_r <= 16'h0000;
      m_rx_sh_r <= 16'h0000;
      m_sout_r <= `SSP_SOUT_IDLE;
      m_sout_en_r <= 1'b0;
    end else if (m_start || m_cont) begin
      m_sout_en_r <= 1'b1;
      if (i_cfg.cmdresp) begin
        m_sout_r <= tx_word[`SSP_CTRL_BITS-1];
        m_tx_sh_r <= {tx_word[`SSP_CTRL_BITS-2:0], 9'h000};
      end else begin
        m_sout_r <= `SSP_SOUT_IDLE;
        m_tx_sh_r <= align_msb(tx_word, i_cfg.bits);
      end
    end else if (mstate_r != ST_RUN) begin
      m_sout_r <= `SSP_SOUT_IDLE;
      m_sout_en_r <= 1'b0;
    end else if (tick) begin
      if (m_shf) begin
        m_sout_r <= m_tx_sh_r[15];
        m_tx_sh_r <= {m_tx_sh_r[14:0], 1'b0};
      end
      if (m_cap) begin
        m_rx_sh_r <= {m_rx_sh_r[14:0], sin_s};
      end
    end
  end

  // Slave engine on resynchronised pin edges
  cfg_t s_cfg;
  logic sclk_rise;
  logic sclk_fall;
  logic s_lead;
  logic s_cap;
  logic s_shf;
  logic fss_fall;
  logic s_active;
  logic s_last;
  logic s_reload;
  logic [4:0] s_cnt_r;
  logic [15:0] s_tx_sh_r;
  logic [15:0] s_rx_sh_r;
  logic s_sout_r;

  always_comb begin
    s_cfg = i_cfg;
    if (i_cfg.cmdresp) begin
      s_cfg.cpol = 1'b0;
      s_cfg.cpha = 1'b0;
    end
  end

  assign sclk_rise = sclk_sync_r[1] && !sclk_d_r;
  assign sclk_fall = !sclk_sync_r[1] && sclk_d_r;
  assign fss_fall = !fss_sync_r[1] && fss_d_r;
  assign s_active = !i_cfg.master && i_enable && !fss_sync_r[1];
  assign s_lead = s_cfg.cpol ? sclk_fall : sclk_rise;
  assign s_cap = s_active && (s_cfg.cpha ? (sclk_rise ^ sclk_fall) && !s_lead : s_lead);
  assign s_shf = s_active && (s_cfg.cpha ? s_lead : (sclk_rise ^ sclk_fall) && !s_lead);
  assign s_last = s_cap && (s_cnt_r == i_cfg.bits - 5'h01);
  assign s_reload = s_last && s_cfg.cpha;

  // Queued word aligned to the top bit, zero when nothing is queued
  logic [15:0] s_load_word;
  assign s_load_word = align_msb(tx_avail ? tx_word : 16'h0000, i_cfg.bits);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      s_cnt_r <= 5'h00;
      s_tx_sh_r <= 16'h0000;
      s_rx_sh_r <= 16'h0000;
      s_sout_r <= `SSP_SOUT_IDLE;
    end else if (!s_active) begin
      s_cnt_r <= 5'h00;
      s_sout_r <= `SSP_SOUT_IDLE;
    end else if (fss_fall) begin
      s_cnt_r <= 5'h00;
      if (s_cfg.cpha) begin
        s_tx_sh_r <= align_msb(tx_avail ? tx_word : 16'h0000, i_cfg.bits);
      end else begin
        // Phase 0 slave presents its MSB as select falls
        s_sout_r <= s_load_word[15];
        s_tx_sh_r <= {s_load_word[14:0], 1'b0};
      end
    end else begin
      if (s_cap) begin
        s_rx_sh_r <= {s_rx_sh_r[14:0], sin_s};
        s_cnt_r <= s_last ? 5'h00 : s_cnt_r + 5'h01;
      end
      if (s_reload) begin
        s_tx_sh_r <= align_msb(tx_avail ? tx_word : 16'h0000, i_cfg.bits);
      end else if (s_shf) begin
        s_sout_r <= s_tx_sh_r[15];
        s_tx_sh_r <= {s_tx_sh_r[14:0], 1'b0};
      end
    end
  end

  // Queue hand-offs; a full receive queue drops the word
  assign tx_pop = m_start || m_cont || (s_active && fss_fall && tx_avail) || (s_reload && tx_avail);

  always_comb begin
    if (i_cfg.master) begin
      rx_word = m_rx_sh_r & word_mask(i_cfg.bits);
      rx_push = rx_space && ((m_cont && i_cfg.cmdresp) || m_cont || m_end);
    end else begin
      rx_word = {s_rx_sh_r[14:0], sin_s} & word_mask(i_cfg.bits);
      rx_push = rx_space && s_last;
    end
  end

  // Pads: enables are active low
  assign o_serial_bit_clock = m_sclk_r;
  assign o_serial_bit_clock_oe_n = !i_cfg.master;
  assign o_frame_select_line = m_fss_r;
  assign o_frame_select_line_oe_n = !i_cfg.master;
  assign o_serial_out_line = i_cfg.master ? m_sout_r : s_sout_r;
  assign o_serial_out_line_oe_n = i_cfg.master ? !m_sout_en_r
                                               : !(s_active && !i_cfg.cmdresp);
  assign o_busy = (mstate_r != ST_IDLE) || s_active;

endmodule

// ---- include/ssp_framer_defines.svh ----
// Constants of the synchronous serial frame engine.
// Assumes inclusion by bare name from the include folder.
`ifndef SSP_FRAMER_DEFINES_SVH
`define SSP_FRAMER_DEFINES_SVH

`define SSP_DATA_W 16
`define SSP_FIFO_DEPTH 8
`define SSP_CTRL_BITS 8
`define SSP_MIN_BITS 5'h04
`define SSP_MAX_BITS 5'h10
`define SSP_GAP_HALVES 6'h02
`define SSP_FSS_IDLE 1'b1
`define SSP_SOUT_IDLE 1'b0
`define SSP_HALF_DIV_RST 8'h04

`endif

// ---- include/ssp_framer_pkg.sv ----
// Types shared by the frame engine and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package ssp_framer_pkg;

  typedef struct packed {
    logic master;
    logic cmdresp;
    logic cpol;
    logic cpha;
    logic [4:0] bits;
  } cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_GAP = 3'b100
  } mstate_t;

endpackage

// ---- verification/spi_peer_model.sv ----
// Far-side peripheral: SPI slave or command responder, behavioural.
// Assumes the bench holds its select high while the port is not master.
`timescale 1ns/1ns
module spi_peer_model
  import ssp_framer_pkg::*;
(
  input wire logic i_sclk,
  input wire logic i_fss,
  input wire logic i_mosi,
  input wire cfg_t i_cfg,
  input wire logic [15:0] i_reply,
  output logic o_miso,
  output logic [15:0] o_got,
  output logic o_got_tgl
);
  logic [15:0] sh;
  int cnt;
  logic first;
  initial begin
    o_miso = 1'b0;
    o_got = 16'h0000;
    o_got_tgl = 1'b0;
    cnt = 0;
  end
  // No pull on the line, so a released line shows the inverse, not a stale bit
  always @(posedge i_fss) o_miso = ~o_miso;
  always @(negedge i_fss) begin
    sh = i_reply << (5'h10 - i_cfg.bits);
    cnt = 0;
    first = i_cfg.cpha;
    if (!i_cfg.cmdresp && !i_cfg.cpha) o_miso = sh[15];
  end
  always @(i_sclk) begin
    if (!i_fss && i_cfg.cmdresp) begin
      if (i_sclk) begin
        cnt = cnt + 1;
        if (cnt <= 8) o_got = {o_got[14:0], i_mosi};
        if (cnt == 8) o_got_tgl = ~o_got_tgl;
        if (cnt == 9 + i_cfg.bits) begin
          cnt = 0;
          sh = i_reply << (5'h10 - i_cfg.bits);
        end
      end else if (cnt >= 9) begin
        o_miso = sh[15];
        sh = sh << 1;
      end else if (cnt == 0) o_miso = ~o_miso;
    end else if (!i_fss) begin
      if ((i_sclk != i_cfg.cpol) ^ i_cfg.cpha) begin
        o_got = {o_got[14:0], i_mosi};
        cnt = cnt + 1;
        if (cnt == i_cfg.bits) begin
          o_got_tgl = ~o_got_tgl;
          cnt = 0;
          first = i_cfg.cpha;
          sh = i_reply << (5'h10 - i_cfg.bits);
        end
      end else begin
        if (!first) sh = sh << 1;
        first = 1'b0;
        o_miso = sh[15];
      end
    end
  end
endmodule

// ---- verification/ssp_framer_chk.sv ----
// Pin timing checker of the frame engine, bound to its top module.
// Assumes the link spacing check only where the half bit is four clocks.
`timescale 1ns/1ns
module ssp_framer_chk
  import ssp_framer_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_enable,
  input wire cfg_t i_cfg,
  input wire logic [7:0] i_half_div,
  input wire logic o_busy,
  input wire logic o_serial_bit_clock,
  input wire logic o_serial_bit_clock_oe_n,
  input wire logic o_frame_select_line,
  input wire logic o_frame_select_line_oe_n,
  input wire logic o_serial_out_line,
  input wire logic o_serial_out_line_oe_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  wire m = i_cfg.master;
  wire spi = m && !i_cfg.cmdresp;
  wire sck = o_serial_bit_clock;
  wire fss = o_frame_select_line;
  a_idle_pins: assert property (m && !o_busy |-> fss && !o_serial_out_line)
    else $error("idle pin levels wrong");
  a_pad_owner: assert property (o_serial_bit_clock_oe_n == !m && o_frame_select_line_oe_n == !m)
    else $error("pad ownership wrong");
  a_start_out: assert property (m && $fell(fss) |-> !o_serial_out_line_oe_n && $past(i_enable))
    else $error("frame start without enable or data out");
  a_lead_edge: assert property (spi && i_cfg.cpha && $fell(fss) |->
    (sck == i_cfg.cpol)[*4] ##1 sck != i_cfg.cpol)
    else $error("phase one first edge misplaced");
  a_late_edge: assert property (spi && !i_cfg.cpha && $fell(fss) |->
    (sck == i_cfg.cpol)[*8] ##1 sck != i_cfg.cpol)
    else $error("phase zero first edge misplaced");
  a_cmd_rise: assert property (m && i_cfg.cmdresp && $fell(fss) |-> (!sck)[*4] ##1 sck)
    else $error("command first rising edge misplaced");
  a_gap_high: assert property (m && $rose(fss) |-> fss[*8])
    else $error("select high pulse too short");
  a_sel_rise: assert property (m && $rose(fss) |-> $past(sck, 9) != $past(sck, 8))
    else $error("select not one bit after last capture");
  a_edge_space: assert property (m && i_half_div == 8'h04 && $changed(sck) && !fss |=>
    $stable(sck)[*3])
    else $error("bit clock half period wrong");
endmodule
bind ssp_framer ssp_framer_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
  .i_clk, .i_sys_rst, .i_enable, .i_cfg, .i_half_div, .o_busy, .o_serial_bit_clock,
  .o_serial_bit_clock_oe_n, .o_frame_select_line, .o_frame_select_line_oe_n,
  .o_serial_out_line, .o_serial_out_line_oe_n
);

// ---- verification/ssp_framer_tb.sv ----
// Bench of the frame engine: master runs face the peer model, slave runs are driven here.
// Assumes the checker binds itself to the engine.
`timescale 1ns/1ns
module ssp_framer_tb;
  import ssp_framer_pkg::*;
  logic i_clk = 1'b0;
  logic rst = 1'b1, en = 1'b1, tx_valid = 1'b0, rx_ready = 1'b1;
  logic sclk_s = 1'b0, fss_s = 1'b1, sin_s = 1'b0;
  cfg_t cfg = 9'h148;
  logic [15:0] tx_data = 16'h0000, reply = 16'h0000, rx_data, peer_got;
  logic tx_ready, rx_valid, busy, sclk_o, sclk_oe_n, fss_o, fss_oe_n, sout, sout_oe_n;
  logic miso, peer_tgl;
  logic [15:0] q_rx[$], q_tx[$];
  int miscompares = 0, cmp_count = 0, cyc = 0;
  wire sclk_w = sclk_oe_n ? sclk_s : sclk_o;
  wire fss_w = fss_oe_n ? fss_s : fss_o;
  wire sin_w = cfg.master ? miso : sin_s;
  wire [15:0] mask = 16'hFFFF >> (5'h10 - cfg.bits);
  ssp_framer i_dut (
    .i_clk(i_clk), .i_sys_rst(rst), .i_enable(en), .i_cfg(cfg), .i_half_div(8'h04),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data),
    .o_rx_valid(rx_valid), .i_rx_ready(rx_ready), .o_rx_data(rx_data), .o_busy(busy),
    .o_serial_bit_clock(sclk_o), .o_serial_bit_clock_oe_n(sclk_oe_n),
    .i_serial_bit_clock(sclk_w), .o_frame_select_line(fss_o),
    .o_frame_select_line_oe_n(fss_oe_n), .i_frame_select_line(fss_w),
    .o_serial_out_line(sout), .o_serial_out_line_oe_n(sout_oe_n), .i_serial_in_line(sin_w)
  );
  spi_peer_model i_peer (
    .i_sclk(sclk_w), .i_fss(fss_w | ~cfg.master), .i_mosi(sout), .i_cfg(cfg),
    .i_reply(reply), .o_miso(miso), .o_got(peer_got), .o_got_tgl(peer_tgl)
  );
  always #25 i_clk = ~i_clk;
  task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("TB: counts miscompares=%0d compares=%0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    rx_ready <= 1'($urandom_range(1));
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
    if (rx_valid && rx_ready) cmp("rx_data", q_rx.pop_front(), rx_data);
  end
  // Each word the peer takes in is matched against the oldest queued expectation
  always @(peer_tgl) if (!rst) cmp("peer_word", q_tx.pop_front(), peer_got & (cfg.cmdresp ? 16'h00FF : mask));
  task automatic drain();
    int k;
    k = 0;
    while ((q_rx.size() != 0 || q_tx.size() != 0 || busy !== 1'b0) && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    repeat (10) @(posedge i_clk);
  endtask
  task automatic run(input logic [2:0] mode, input logic [4:0] nb, input logic hold);
    logic [15:0] w0, w1, r, m;
    w0 = 16'($urandom);
    w1 = 16'($urandom);
    r = 16'($urandom);
    m = 16'hFFFF >> (5'h10 - nb);
    cfg <= {1'b1, mode[2], mode[1:0], nb};
    reply <= r;
    en <= !hold;
    repeat (8) @(posedge i_clk);
    q_tx.push_back(mode[2] ? {8'h00, w0[7:0]} : w0 & m);
    q_tx.push_back(mode[2] ? {8'h00, w1[7:0]} : w1 & m);
    q_rx.push_back(r & m);
    q_rx.push_back(r & m);
    tx_valid <= 1'b1;
    tx_data <= w0;
    @(posedge i_clk);
    tx_data <= w1;
    @(posedge i_clk);
    tx_valid <= 1'b0;
    if (hold) begin
      repeat (40) @(posedge i_clk);
      cmp("fss_held", 16'h0001, {15'h0000, fss_o});
      en <= 1'b1;
    end
    drain();
  endtask
  task automatic slave(input logic [15:0] d, input logic [4:0] n, input logic cr);
    cfg <= {1'b0, cr, 2'b00, n};
    q_rx.push_back(d & (16'hFFFF >> (5'h10 - n)));
    repeat (8) @(posedge i_clk);
    // Link clock offset from the system clock, still outside the frame
    #13 fss_s = 1'b0;
    sin_s = d[n-1];
    #800;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_s = 1'b1;
      #200 sclk_s = 1'b0;
      sin_s = (i > 0) ? d[i-1] : ~sin_s;
      #200;
    end
    fss_s = 1'b1;
    sin_s = ~sin_s;
    drain();
  endtask
  initial begin
    void'($urandom(65238));
    repeat (4) @(posedge i_clk);
    rst <= 1'b0;
    repeat (8) @(posedge i_clk);
    cmp("idle_pins", 16'h0006, {13'h0000, sclk_o, fss_o, sout});
    cmp("tx_ready", 16'h0001, {15'h0000, tx_ready});
    for (int i = 0; i < 5; i++) begin
      run(3'(i), (i == 0) ? 5'h04 : (i == 4) ? 5'h10 : 5'($urandom_range(16, 4)), i == 0);
    end
    slave(16'($urandom), 5'h04, 1'b0);
    slave(16'($urandom), 5'h10, 1'b0);
    slave(16'($urandom), 5'h0C, 1'b1);
    cmp("pending", 16'h0000, 16'(q_rx.size() + q_tx.size()));
    results();
  end
endmodule
